// *** logic/dpt_timer.sv ***
`timescale 1ns/10ps
// Dual 8-bit programmable down timer with APB register access.
module dpt_timer #(
  parameter int LATCH_CYC = dpt_pkg::LATCH_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        input_port_pin,
  input  wire logic        cpu_mask_bit_lo,
  input  wire logic        cpu_mask_bit_hi,
  output logic             output_port_pin,
  output logic             irq_req,
  output logic [1:0]       irq_level
);

  // ----------------------------------------
  // Registers.
  // ----------------------------------------
  logic [1:0]       prio_r;      // Interrupt priority level.
  logic [1:0]       en_r;        // Interrupt enables, timer 1 in bit 1.
  logic [1:0]       flag_r;      // Interrupt factor flags.
  logic             wide_r;      // Combined 16-bit mode.
  logic             out_source_select_r;     // Output source select.
  logic             outen_r;     // Output enable.
  dpt_pkg::dpt_ctl_s ctl_r [2];  // Channel control fields.
  logic [1:0]       run_req_r;   // Run bits as software wrote them.
  logic [1:0]       act_r;       // Counter really running.
  logic [7:0]       rld_r [2];   // Reload values.
  logic [7:0]       cnt_r [2];   // Down counters.
  logic [7:0]       rd_r [2];    // Readout buffers.
  logic             hold_r;      // High readout latched.
  logic [15:0]      hold_cnt_r;  // Age of the high-byte latch.
  logic [5:0]       pre_r;       // Free-running prescaler.
  logic             ev_d_r;      // Last synchronised input level.
  logic             timer_out_signal_r;      // Square output toggled on underflow.
  logic             pready_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;
  logic             out_pin_r;
  logic             irq_req_r;
  logic [1:0]       irq_level_r;
  logic             ev_q;        // Synchronised external input.

  // ----------------------------------------
  // External input synchroniser.
  // ----------------------------------------
  dpt_pin_sync u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin     (input_port_pin),
    .level_r (ev_q)
  );

  // ----------------------------------------
  // Address decode.
  // ----------------------------------------
  // Tells whether the bus address selects the register of a given index.
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[17:2] == idx);
  endfunction

  // Prescaler mask for a divide ratio of 1, 4, 16 or 64.
  function automatic logic [5:0] psc_mask(input logic [1:0] psc);
    case (psc)
      2'h0:    psc_mask = 6'h00;
      2'h1:    psc_mask = 6'h03;
      2'h2:    psc_mask = 6'h0f;
      default: psc_mask = 6'h3f;
    endcase
  endfunction

  wire h_prio  = hit(paddr, dpt_pkg::IDX_PRIO);
  wire h_en    = hit(paddr, dpt_pkg::IDX_EN);
  wire h_flag  = hit(paddr, dpt_pkg::IDX_FLAG);
  wire h_gctl  = hit(paddr, dpt_pkg::IDX_GCTL);
  wire h_ctl0  = hit(paddr, dpt_pkg::IDX_T0CTL);
  wire h_ctl1  = hit(paddr, dpt_pkg::IDX_T1CTL);
  wire h_rld0  = hit(paddr, dpt_pkg::IDX_T0RLD);
  wire h_rld1  = hit(paddr, dpt_pkg::IDX_T1RLD);
  wire h_cnt0  = hit(paddr, dpt_pkg::IDX_T0CNT);
  wire h_cnt1  = hit(paddr, dpt_pkg::IDX_T1CNT);
  wire h_any   = h_prio | h_en | h_flag | h_gctl | h_ctl0 | h_ctl1 | h_rld0 | h_rld1 | h_cnt0 | h_cnt1;

  // The slave inserts one wait state so that read data leave a flip-flop.
  wire acc     = psel & penable;
  wire done    = acc & pready_r;
  wire wr      = done & pwrite & h_any;
  wire rd_take = acc & ~pready_r & ~pwrite;
  wire [7:0] wd = pwdata[7:0];

  // Read value of each control register; preset always reads zero.
  wire [1:0] run_rd = run_req_r | act_r;
  wire [7:0] ctl0_rd = {ctl_r[0].event_count_select, ctl_r[0].function_select, ctl_r[0].pol, ctl_r[0].psc,
                        ctl_r[0].cont, 1'b0, run_rd[0]};
  wire [7:0] ctl1_rd = {3'h0, ctl_r[1].psc, ctl_r[1].cont, 1'b0, run_rd[1]};
  wire [7:0] rd_mux =
    h_prio ? {4'h0, prio_r, 2'h0} :
    h_en   ? {en_r, 6'h00} :
    h_flag ? {flag_r, 6'h00} :
    h_gctl ? {3'h0, wide_r, out_source_select_r, outen_r, 2'h0} :
    h_ctl0 ? ctl0_rd :
    h_ctl1 ? ctl1_rd :
    h_rld0 ? rld_r[0] :
    h_rld1 ? rld_r[1] :
    h_cnt0 ? rd_r[0] :
    h_cnt1 ? rd_r[1] : 8'h00;

  // ----------------------------------------
  // Write strobes for the self-clearing and run bits.
  // ----------------------------------------
  wire wr_ctl0  = wr & h_ctl0;
  wire wr_ctl1  = wr & h_ctl1;
  wire t0_preset    = wr_ctl0 & wd[dpt_pkg::C_PRESET];
  wire t1_preset    = wr_ctl1 & wd[dpt_pkg::C_PRESET] & ~wide_r;
  wire flag_clr0 = wr & h_flag & wd[dpt_pkg::EN_T0_BIT];
  wire flag_clr1 = wr & h_flag & wd[dpt_pkg::EN_T1_BIT];

  // ----------------------------------------
  // Count enables.
  // ----------------------------------------
  wire tick0 = (pre_r & psc_mask(ctl_r[0].psc)) == 6'h00;
  // In wide mode the high byte follows the low byte's clock.
  wire tick1 = (pre_r & psc_mask(ctl_r[1].psc)) == 6'h00;
  wire ev_edge = ctl_r[0].pol ? (ev_q & ~ev_d_r) : (~ev_q & ev_d_r);
  // Polarity gates pulse measurement and also picks the counted edge in event mode.
  wire gate_ok = ~ctl_r[0].function_select | (ev_q == ctl_r[0].pol);
  wire dec0 = ctl_r[0].event_count_select ? (run_req_r[0] & ev_edge) : (tick0 & act_r[0] & gate_ok);
  wire dec1 = tick1 & act_r[1] & ~wide_r;
  wire z0   = cnt_r[0] == 8'h00;
  wire z1   = cnt_r[1] == 8'h00;
  wire uf_w = wide_r & dec0 & z0 & z1;
  wire uf0  = ~wide_r & dec0 & z0;
  wire uf1  = ~wide_r & dec1 & z1;
  wire borrow = wide_r & dec0 & z0 & ~z1;
  wire stop0 = (uf0 | uf_w) & ~ctl_r[0].cont;
  wire stop1 = uf1 & ~ctl_r[1].cont;
  wire src_uf = wide_r ? uf_w : (out_source_select_r ? uf1 : uf0);

  // Next counter values; reload only on preset or underflow.
  wire ld0 = t0_preset | uf0 | uf_w;
  wire ld1 = (t0_preset & wide_r) | t1_preset | uf1 | uf_w;
  wire [7:0] cnt0_nxt = ld0 ? rld_r[0] : (dec0 ? cnt_r[0] - 8'h01 : cnt_r[0]);
  wire [7:0] cnt1_nxt = ld1 ? rld_r[1] : ((dec1 | borrow) ? cnt_r[1] - 8'h01 : cnt_r[1]);

  // Run bits after software writes and one-shot stops.
  wire [1:0] run_req_nxt;
  assign run_req_nxt[0] = stop0 ? 1'b0 : (wr_ctl0 ? wd[dpt_pkg::C_RUN] : run_req_r[0]);
  assign run_req_nxt[1] = (stop1 | wide_r) ? 1'b0 :
                          (wr_ctl1 ? wd[dpt_pkg::C_RUN] : run_req_r[1]);

  // The running state follows the run bit only on a counting tick, so a
  // stop lets one more decrement happen first. Event mode follows at once.
  wire [1:0] act_nxt;
  assign act_nxt[0] = stop0 ? 1'b0 :
                      ctl_r[0].event_count_select ? run_req_r[0] :
                      (tick0 ? run_req_r[0] : act_r[0]);
  assign act_nxt[1] = (stop1 | wide_r) ? 1'b0 : (tick1 ? run_req_r[1] : act_r[1]);

  // Interrupt request against the processor mask level.
  wire [1:0] cpu_mask = {cpu_mask_bit_hi, cpu_mask_bit_lo};
  wire [1:0] en_eff   = {en_r[1], en_r[0] & ~wide_r};
  wire irq_nxt = (|(flag_r & en_eff)) && (prio_r > cpu_mask);

  // High-byte latch: a low read in wide mode sets it, a high read or the
  // timeout frees it.
  wire lat_set = rd_take & h_cnt0 & wide_r;
  wire lat_clr = (rd_take & h_cnt1) | (hold_cnt_r == LATCH_CYC[15:0] - 16'h0001);

  // ----------------------------------------
  // Bus slave handshake and read data.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~h_any;
      // Unmapped reads return zero, and a write clears the read data so that a
      // refused write never shows stale data beside its error flag.
      if (acc & ~pready_r) begin
        prdata_r <= {24'h00_0000, pwrite ? 8'h00 : rd_mux};
      end
    end
  end

  // ----------------------------------------
  // Configuration registers.
  // ----------------------------------------
  // Reserved bits are dropped on write and read back as zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prio_r  <= 2'h0;
      en_r    <= 2'h0;
      wide_r  <= 1'b0;
      out_source_select_r <= 1'b0;
      outen_r <= 1'b0;
      rld_r[0] <= dpt_pkg::RLD_RST;
      rld_r[1] <= dpt_pkg::RLD_RST;
    end else begin
      if (wr & h_prio) begin
        prio_r <= wd[dpt_pkg::PRIO_LSB +: 2];
      end
      if (wr & h_en) begin
        en_r <= {wd[dpt_pkg::EN_T1_BIT], wd[dpt_pkg::EN_T0_BIT]};
      end
      if (wr & h_gctl) begin
        wide_r  <= wd[dpt_pkg::G_WIDE];
        out_source_select_r <= wd[dpt_pkg::G_OUT_SOURCE_SELECT];
        outen_r <= wd[dpt_pkg::G_OUTEN];
      end
      if (wr & h_rld0) begin
        rld_r[0] <= wd;
      end
      if (wr & h_rld1) begin
        rld_r[1] <= wd;
      end
    end
  end

  // ----------------------------------------
  // Channel control fields, one per channel.
  // ----------------------------------------
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ctl
      wire wr_this = (i == 0) ? wr_ctl0 : wr_ctl1;
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          ctl_r[i] <= '0;
        end else if (wr_this) begin
          // Timer 1 has no input-related fields.
          ctl_r[i].event_count_select <= (i == 0) ? wd[dpt_pkg::C_EVENT_COUNT_SELECT] : 1'b0;
          ctl_r[i].function_select <= (i == 0) ? wd[dpt_pkg::C_FUNCTION_SELECT] : 1'b0;
          ctl_r[i].pol   <= (i == 0) ? wd[dpt_pkg::C_POL] : 1'b0;
          ctl_r[i].psc   <= wd[dpt_pkg::C_PSC_LSB +: 2];
          ctl_r[i].cont  <= wd[dpt_pkg::C_CONT];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Counters, run state and prescaler.
  // ----------------------------------------
  // The prescaler runs free and is shared by both channels, so a run write
  // waits up to two divided periods before the counter moves. That saves a
  // divider per channel at the cost of a start latency software must allow.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r[0]  <= dpt_pkg::CNT_RST;
      cnt_r[1]  <= dpt_pkg::CNT_RST;
      run_req_r <= 2'h0;
      act_r     <= 2'h0;
      pre_r     <= 6'h00;
      ev_d_r    <= 1'b0;
    end else begin
      cnt_r[0]  <= cnt0_nxt;
      cnt_r[1]  <= cnt1_nxt;
      run_req_r <= run_req_nxt;
      act_r     <= act_nxt;
      pre_r     <= pre_r + 6'h01;
      ev_d_r    <= ev_q;
    end
  end

  // ----------------------------------------
  // Interrupt factor flags; a new underflow wins over a clear.
  // ----------------------------------------
  // A clear that lands in the cycle of an underflow loses, so software never
  // misses an event that arrived while it acknowledged the previous one.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_r <= 2'h0;
    end else begin
      flag_r[0] <= uf0 | (flag_r[0] & ~flag_clr0);
      flag_r[1] <= uf1 | uf_w | (flag_r[1] & ~flag_clr1);
    end
  end

  // ----------------------------------------
  // Readout buffers and the high-byte latch.
  // ----------------------------------------
  // The latch age counter only runs while the latch is held, so an idle
  // block keeps it still.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_r[0]    <= dpt_pkg::CNT_RST;
      rd_r[1]    <= dpt_pkg::CNT_RST;
      hold_r     <= 1'b0;
      hold_cnt_r <= 16'h0000;
    end else begin
      rd_r[0] <= cnt_r[0];
      // Freezing the high byte keeps a borrow from tearing a 16-bit read.
      if (!(hold_r || lat_set)) begin
        rd_r[1] <= cnt_r[1];
      end
      if (lat_set) begin
        hold_r     <= 1'b1;
        hold_cnt_r <= 16'h0000;
      end else if (hold_r && lat_clr) begin
        hold_r     <= 1'b0;
        hold_cnt_r <= 16'h0000;
      end else if (hold_r) begin
        hold_cnt_r <= hold_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Square output and interrupt outputs.
  // ----------------------------------------
  // Every output leaves a flip-flop, so the pins see no decode glitches.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_out_signal_r      <= 1'b0;
      out_pin_r   <= 1'b1;
      irq_req_r   <= 1'b0;
      irq_level_r <= 2'h0;
    end else begin
      timer_out_signal_r      <= timer_out_signal_r ^ src_uf;
      // Disabled output rests high, so no glitch reaches the pin here.
      out_pin_r   <= outen_r ? timer_out_signal_r : 1'b1;
      irq_req_r   <= irq_nxt;
      irq_level_r <= prio_r;
    end
  end

  assign pready          = pready_r;
  assign prdata          = prdata_r;
  assign pslverr         = pslverr_r;
  assign output_port_pin = out_pin_r;
  assign irq_req         = irq_req_r;
  assign irq_level       = irq_level_r;

endmodule // dpt_timer

// *** logic/dpt_pkg.sv ***
// Function
// - Pulse mode: polarity 1 high width, 0 low
// - Polarity ignored in normal mode; resets 0
// - Continuous mode reloads on underflow, keeps counting
// - One-shot underflow reloads, stops, clears run bit
// - Reload value 8 bits, resets all ones
// - Reload copied only on preset or underflow
// - Readout buffered; low read in wide mode latches high byte
// - High latch freed by high read or timeout
// - Count readouts read-only, reset all ones
// - Preset loads reload; reads zero; zero ignored
// - Wide mode ignores timer 1 preset
// - Run bit starts and stops; resets zero
// - Output source select; wide uses combined underflow
// - Output enable drives signal, else steady high
// - Two-bit priority level; zero means none
// - Enable bits reset zero; t0 ignored wide
// - Underflow sets flag regardless of enable
// - Request when flag, enable, priority above mask
// - Writing one clears flag; zero ignored
// - Wide mode: only timer 1 flag sets
// - Run/stop on tick; one more decrement
// - Mode bit: two 8-bit or one 16-bit
// - Event count bit counts external input edges
package dpt_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_PRIO  = 16'hff21;
  localparam logic [15:0] IDX_EN    = 16'hff23;
  localparam logic [15:0] IDX_FLAG  = 16'hff25;
  localparam logic [15:0] IDX_GCTL  = 16'hff30;
  localparam logic [15:0] IDX_T0CTL = 16'hff31;
  localparam logic [15:0] IDX_T1CTL = 16'hff32;
  localparam logic [15:0] IDX_T0RLD = 16'hff33;
  localparam logic [15:0] IDX_T1RLD = 16'hff34;
  localparam logic [15:0] IDX_T0CNT = 16'hff35;
  localparam logic [15:0] IDX_T1CNT = 16'hff36;

  // Field positions.
  localparam int PRIO_LSB  = 2;
  localparam int EN_T0_BIT = 6;
  localparam int EN_T1_BIT = 7;
  localparam int G_WIDE    = 4;
  localparam int G_OUT_SOURCE_SELECT   = 3;
  localparam int G_OUTEN   = 2;
  localparam int C_EVENT_COUNT_SELECT   = 7;
  localparam int C_FUNCTION_SELECT   = 6;
  localparam int C_POL     = 5;
  localparam int C_PSC_LSB = 3;
  localparam int C_CONT    = 2;
  localparam int C_PRESET  = 1;
  localparam int C_RUN     = 0;

  // Reset values.
  localparam logic [7:0] RLD_RST = 8'hff;
  localparam logic [7:0] CNT_RST = 8'hff;

  // High-byte latch release time and the clock rate.
  localparam int LATCH_REL_NS = 730000;
  localparam int CLK_MHZ      = 20;
  localparam int LATCH_CYC    = (LATCH_REL_NS * CLK_MHZ + 999) / 1000;

  // Per-channel control fields.
  typedef struct packed {
    logic       event_count_select;
    logic       function_select;
    logic       pol;
    logic [1:0] psc;
    logic       cont;
  } dpt_ctl_s;

endpackage

// *** logic/dpt_pin_sync.sv ***
`timescale 1ns/10ps
// Brings a pin into the clock domain; a change counts once stages two and
// three agree, which rejects a single-cycle disagreement.
module dpt_pin_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level_r
);

  logic s1_r; // First stage; only the second stage reads it.
  logic s2_r; // Second stage.
  logic s3_r; // Third stage.

  // ----------------------------------------
  // Three-stage chain with agreement filter.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule // dpt_pin_sync

// *** sim/dpt_timer_properties.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port-level checker for the dual down timer.
// ----------------------------------------------------------------
module dpt_timer_properties #(
  parameter int LATCH_CYC = dpt_pkg::LATCH_CYC
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        input_port_pin,
  input wire logic        cpu_mask_bit_lo,
  input wire logic        cpu_mask_bit_hi,
  input wire logic        output_port_pin,
  input wire logic        irq_req,
  input wire logic [1:0]  irq_level
);
  logic [15:0] acc_idx;  // Register index of the current access.
  logic        mapped;   // High when the index names a register.
  logic        wr_prio;  // Completed write to the priority register.
  assign acc_idx = paddr[17:2];
  assign mapped  = acc_idx inside {dpt_pkg::IDX_PRIO, dpt_pkg::IDX_EN, dpt_pkg::IDX_FLAG,
                                   [dpt_pkg::IDX_GCTL:dpt_pkg::IDX_T1CNT]};
  assign wr_prio = psel && penable && pready && pwrite && (acc_idx == dpt_pkg::IDX_PRIO);

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Bus answer timing and content.
  // ----------------------------------------------------------------
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing one cycle into the access phase");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_err_unmapped: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");

  // ----------------------------------------------------------------
  // Interrupt level and request.
  // ----------------------------------------------------------------
  a_level_write: assert property (wr_prio |-> ##2 irq_level == $past(pwdata[3:2], 2))
    else $error("irq_level does not follow the priority write");
  a_level_hold: assert property (!$past(wr_prio, 2) |-> $stable(irq_level))
    else $error("irq_level changed without a priority write");
  a_irq_above_mask: assert property (irq_req && $stable(irq_level) |->
                                     irq_level > $past({cpu_mask_bit_hi, cpu_mask_bit_lo}))
    else $error("irq_req raised at or below the mask level");

  c_refused: cover property (pslverr);
  c_irq: cover property (irq_req);
  c_prio_write: cover property (wr_prio);
endmodule // dpt_timer_properties

// *** sim/test_dpt_timer.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Register-level bench for the dual down timer.
// ----------------------------------------------------------------
module test_dpt_timer;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, rd_w;
  logic        input_port_pin, cpu_mask_bit_lo, cpu_mask_bit_hi;
  logic        output_port_pin, irq_req, er_v, last_pin;
  logic [1:0]  irq_level;
  int          err_total, cmp_count, n_tog;
  // Reset table: index and expected value, in register map order.
  logic [15:0] rst_ix [10] = '{dpt_pkg::IDX_PRIO, dpt_pkg::IDX_EN, dpt_pkg::IDX_FLAG, dpt_pkg::IDX_GCTL,
                                dpt_pkg::IDX_T0CTL, dpt_pkg::IDX_T1CTL, dpt_pkg::IDX_T0RLD,
                                dpt_pkg::IDX_T1RLD, dpt_pkg::IDX_T0CNT, dpt_pkg::IDX_T1CNT};
  logic [7:0]  rst_val [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff};

  // A short latch time keeps the run brief.
  dpt_timer #(.LATCH_CYC(16)) dpt_timer_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .input_port_pin(input_port_pin), .cpu_mask_bit_lo(cpu_mask_bit_lo), .cpu_mask_bit_hi(cpu_mask_bit_hi),
    .output_port_pin(output_port_pin), .irq_req(irq_req), .irq_level(irq_level));

  // Free-running 20 MHz clock.
  always #25 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus and comparison tasks.
  // ----------------------------------------------------------------
  // One APB transfer; an idle cycle follows so psel is never driven twice in a step.
  task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(negedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    // Values settled at the falling edge are those the next rising edge samples.
    rd = prdata;
    er = pslverr;
    @(posedge clock);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      err_total++;
      $display("MISMATCH pready exp 1 got none");
    end
    @(posedge clock);
  endtask

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d, rd_w, er_v);
  endtask

  task automatic chk(input logic [15:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00, rd_v, er_v);
    cmp($sformatf("reg %h", ix), {24'h0, e}, rd_v);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 700 cycles.
  initial begin
    wait_cyc(20000);
    err_total++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    {clock, rst_n, psel, penable, pwrite, input_port_pin, cpu_mask_bit_lo, cpu_mask_bit_hi} = '0;
    paddr = '0;
    pwdata = '0;
    err_total = 0;
    cmp_count = 0;
    wait_cyc(8);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      chk(rst_ix[i], rst_val[i]);
    end
    cmp("pin", 32'h1, {31'h0, output_port_pin});
    wr(dpt_pkg::IDX_T0CNT, 8'h12);
    chk(dpt_pkg::IDX_T0CNT, 8'hff);
    apb(1'b0, 16'hff22, 8'h00, rd_v, er_v);
    cmp("unmapped err", 32'h1, {31'h0, er_v});
    // One-shot timer 0 from a preset value.
    wr(dpt_pkg::IDX_T0RLD, 8'h05);
    wr(dpt_pkg::IDX_T0CTL, 8'h02);
    chk(dpt_pkg::IDX_T0CNT, 8'h05);
    chk(dpt_pkg::IDX_T0CTL, 8'h00);
    wr(dpt_pkg::IDX_T0CTL, 8'h01);
    wait_cyc(20);
    chk(dpt_pkg::IDX_T0CTL, 8'h00);
    chk(dpt_pkg::IDX_T0CNT, 8'h05);
    chk(dpt_pkg::IDX_FLAG, 8'h40);
    wr(dpt_pkg::IDX_FLAG, 8'h40);
    // Continuous timer 1 driving the output pin.
    wr(dpt_pkg::IDX_GCTL, 8'h0c);
    wr(dpt_pkg::IDX_T1RLD, 8'h03);
    wr(dpt_pkg::IDX_T1CTL, 8'h06);
    wr(dpt_pkg::IDX_T1CTL, 8'h05);
    last_pin = output_port_pin;
    n_tog = 0;
    repeat (40) begin
      @(negedge clock);
      if (output_port_pin !== last_pin) n_tog++;
      last_pin = output_port_pin;
    end
    cmp("timer_out_signal toggles", 32'h1, {31'h0, n_tog >= 9 && n_tog <= 11});
    chk(dpt_pkg::IDX_T1CTL, 8'h05);
    wr(dpt_pkg::IDX_T1CTL, 8'h04);
    wait_cyc(4);
    chk(dpt_pkg::IDX_T1CTL, 8'h04);
    apb(1'b0, dpt_pkg::IDX_T1CNT, 8'h00, rd_w, er_v);
    // Reads seven cycles apart would differ on a running period-four counter.
    wait_cyc(3);
    chk(dpt_pkg::IDX_T1CNT, rd_w[7:0]);
    wr(dpt_pkg::IDX_GCTL, 8'h00);
    // Interrupt request against the mask level.
    wr(dpt_pkg::IDX_PRIO, 8'h0c);
    wr(dpt_pkg::IDX_EN, 8'h80);
    wait_cyc(2);
    cmp("irq_req", 32'h1, {31'h0, irq_req});
    cmp("irq_level", 32'h3, {30'h0, irq_level});
    {cpu_mask_bit_hi, cpu_mask_bit_lo} <= 2'b11;
    wait_cyc(2);
    cmp("irq_req", 32'h0, {31'h0, irq_req});
    {cpu_mask_bit_hi, cpu_mask_bit_lo} <= 2'b00;
    wr(dpt_pkg::IDX_FLAG, 8'h00);
    chk(dpt_pkg::IDX_FLAG, 8'h80);
    wr(dpt_pkg::IDX_FLAG, 8'h80);
    wait_cyc(2);
    cmp("irq_req", 32'h0, {31'h0, irq_req});
    chk(dpt_pkg::IDX_FLAG, 8'h00);
    // Combined 16-bit counter, one-shot from 0x0102.
    wr(dpt_pkg::IDX_GCTL, 8'h10);
    wr(dpt_pkg::IDX_T0RLD, 8'h02);
    wr(dpt_pkg::IDX_T1RLD, 8'h01);
    wr(dpt_pkg::IDX_T0CTL, 8'h02);
    wr(dpt_pkg::IDX_T1RLD, 8'h07);
    wr(dpt_pkg::IDX_T1CTL, 8'h03);
    chk(dpt_pkg::IDX_T0CNT, 8'h02);
    chk(dpt_pkg::IDX_T1CNT, 8'h01);
    chk(dpt_pkg::IDX_T1CTL, 8'h00);
    wr(dpt_pkg::IDX_T0CTL, 8'h01);
    wait_cyc(300);
    chk(dpt_pkg::IDX_FLAG, 8'h80);
    chk(dpt_pkg::IDX_T0CNT, 8'h02);
    chk(dpt_pkg::IDX_T1CNT, 8'h07);
    wr(dpt_pkg::IDX_GCTL, 8'h00);
    // High-width measurement: a low input must not count.
    wr(dpt_pkg::IDX_T0RLD, 8'h10);
    wr(dpt_pkg::IDX_T0CTL, 8'h02);
    wr(dpt_pkg::IDX_T0CTL, 8'h61);
    wait_cyc(20);
    chk(dpt_pkg::IDX_T0CNT, 8'h10);
    // A high input counts down to the one-shot underflow; timer 1's flag remains.
    input_port_pin <= 1'b1;
    wait_cyc(40);
    chk(dpt_pkg::IDX_FLAG, 8'hc0);
    // Event mode on rising edges: three rising edges take three counts.
    wr(dpt_pkg::IDX_T0CTL, 8'ha1);
    repeat (3) begin
      input_port_pin <= 1'b0;
      wait_cyc(6);
      input_port_pin <= 1'b1;
      wait_cyc(6);
    end
    chk(dpt_pkg::IDX_T0CNT, 8'h0d);
    wrap_up;
  end
endmodule // test_dpt_timer

bind dpt_timer dpt_timer_properties #(.LATCH_CYC(LATCH_CYC)) dpt_timer_properties_i (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .input_port_pin(input_port_pin),
  .cpu_mask_bit_lo(cpu_mask_bit_lo), .cpu_mask_bit_hi(cpu_mask_bit_hi),
  .output_port_pin(output_port_pin), .irq_req(irq_req), .irq_level(irq_level));
